// [src/lpac_bank.sv]
/*
  One bank's open/close tracker on the link clock.
  Assumes one command per link cycle and that hit already folds in
  close-all and the bank address.
*/
`timescale 1ns/1ps
module lpac_bank (
  input  wire logic                  ck,
  input  wire logic                  link_rst,
  input  wire lpac_pkg::lpac_cmd_s   cmd,
  input  wire logic                  hit,
  output lpac_pkg::lpac_bank_e       state_q,
  output lpac_pkg::lpac_err_s        err
);

  lpac_pkg::lpac_bank_e          state_d;
  logic [lpac_pkg::CNT_W-1:0]    cnt_q;
  logic [lpac_pkg::CNT_W-1:0]    cnt_d;
  logic [lpac_pkg::CNT_W-1:0]    guard_q;
  logic [lpac_pkg::CNT_W-1:0]    guard_d;

  wire mine     = cmd.valid && hit;
  wire is_act   = mine && cmd.op == lpac_pkg::CMD_ACT;
  wire is_rd    = mine && cmd.op == lpac_pkg::CMD_RD;
  wire is_wr    = mine && cmd.op == lpac_pkg::CMD_WR;
  wire is_close = mine && (cmd.op == lpac_pkg::CMD_CLOSE || cmd.op == lpac_pkg::CMD_CLOSE_ALL);
  wire cnt_last = cnt_q == lpac_pkg::CNT_W'(1);
  wire done_now = state_q == lpac_pkg::B_CLOSING && cnt_last;
  wire cnt_dec  = cnt_q != '0;
  wire grd_dec  = guard_q != '0;

  // Close finishing on this edge counts as idle for an activate
  assign err.act     = is_act && !(state_q == lpac_pkg::B_IDLE || done_now);
  assign err.access  = (is_rd || is_wr) && state_q != lpac_pkg::B_OPEN;
  assign err.close   = is_close && guard_q > lpac_pkg::CNT_W'(1);
  assign err.burst_stop_cmd     = 1'b0;
  assign err.spacing = 1'b0;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_dec ? cnt_q - lpac_pkg::CNT_W'(1) : cnt_q;
    guard_d = grd_dec ? guard_q - lpac_pkg::CNT_W'(1) : guard_q;
    if (is_rd)
      guard_d = lpac_pkg::RD_CLOSE_DLY;
    else if (is_wr)
      guard_d = lpac_pkg::WR_CLOSE_DLY;
    if (is_close)
    begin
      // Period restarts from the latest close aimed at this bank
      state_d = lpac_pkg::B_CLOSING;
      cnt_d   = lpac_pkg::CLOSE_CYC;
    end
    else
    begin
      case (state_q)
        lpac_pkg::B_IDLE:
          if (is_act)
            state_d = lpac_pkg::B_OPEN;
        lpac_pkg::B_OPEN:
          if ((is_rd || is_wr) && cmd.auto_close_flag)
          begin
            state_d = lpac_pkg::B_AP_PEND;
            cnt_d   = is_rd ? lpac_pkg::RD_AP_START : lpac_pkg::WR_AP_START;
          end
          // Without the flag the bank simply stays open
        lpac_pkg::B_AP_PEND:
          if (cnt_last)
          begin
            state_d = lpac_pkg::B_CLOSING;
            cnt_d   = lpac_pkg::CLOSE_CYC;
          end
        default:
          if (cnt_last)
            state_d = is_act ? lpac_pkg::B_OPEN : lpac_pkg::B_IDLE;
      endcase
    end
  end

  always_ff @(posedge ck)
  begin
    if (link_rst)
    begin
      state_q <= lpac_pkg::B_IDLE;
      cnt_q   <= '0;
      guard_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      guard_q <= guard_d;
    end
  end

endmodule

// [src/lpac_pkg.sv]
/*
  Shared types and timing for the auto-close scheduling block of a
  four-bit-prefetch low-power DDR SDRAM. Assumes the command clock period
  below matches the link clock actually supplied by the controller.
*/
package lpac_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int CNT_W     = 8;

  // Mode settings and analog times; plain defaults, not taken from a part
  localparam int BURST_LENGTH   = 8;
  localparam int READ_LATENCY   = 3;
  localparam int WRITE_LATENCY  = 1;
  localparam int LINK_TCK_PS    = 64000;
  localparam int T_RTP_PS       = 7500;   // read_to_close_time
  localparam int T_WR_PS        = 15000;  // write_recovery_time
  localparam int T_RP_PS        = 18000;  // single_bank_close_time
  localparam int T_WTR_PS       = 7500;   // write_to_read_turnaround
  localparam int SYNC_STAGES    = 2;

  // Round a least time up to whole link cycles, never below one
  function automatic int ru_cyc(input int ps);
    int c;
    c = (ps + LINK_TCK_PS - 1) / LINK_TCK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int HALF_BL = BURST_LENGTH / 2;
  localparam int RTP_CYC = ru_cyc(T_RTP_PS);
  localparam int WR_CYC  = ru_cyc(T_WR_PS);
  localparam int RP_CYC  = ru_cyc(T_RP_PS);
  localparam int WTR_CYC = ru_cyc(T_WTR_PS);

  localparam logic [CNT_W-1:0] RD_AP_START  = CNT_W'(imax(HALF_BL, HALF_BL - 2 + RTP_CYC));
  localparam logic [CNT_W-1:0] RD_CLOSE_DLY = CNT_W'(HALF_BL + imax(2, RTP_CYC) - 2);
  localparam logic [CNT_W-1:0] WR_CLOSE_DLY = CNT_W'(WRITE_LATENCY + HALF_BL + WR_CYC + 1);
  localparam logic [CNT_W-1:0] WR_AP_START  = CNT_W'(WRITE_LATENCY + HALF_BL + WR_CYC + 1);
  localparam logic [CNT_W-1:0] CLOSE_CYC    = CNT_W'(RP_CYC);
  localparam logic [CNT_W-1:0] WRAP_TO_RD   = CNT_W'(WRITE_LATENCY + HALF_BL + WTR_CYC + 1);
  localparam logic [CNT_W-1:0] SEAMLESS_GAP = CNT_W'(HALF_BL);
  localparam logic [CNT_W-1:0] BST_LAST     = CNT_W'(HALF_BL - 1);
  localparam logic [CNT_W-1:0] AGE_MAX      = 8'hFF;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_CLOSE, CMD_CLOSE_ALL, CMD_BST
  } lpac_op_e;

  typedef enum logic [1:0] {B_IDLE, B_OPEN, B_AP_PEND, B_CLOSING} lpac_bank_e;

  typedef struct packed {
    logic              valid;
    lpac_op_e          op;
    logic [BANK_W-1:0] bank;
    logic              auto_close_flag;
  } lpac_cmd_s;

  typedef struct packed {
    logic act;      // Activate to a bank that is not idle
    logic access;   // Read or write to a bank that is not open
    logic close;    // Close before the read or write spacing ran out
    logic burst_stop_cmd;      // Burst stop outside its window or on an auto-close access
    logic spacing;  // Access too soon after the previous one
  } lpac_err_s;

  localparam int ERR_W = $bits(lpac_err_s);

endpackage

// [src/lpac_top.sv]
/*
  Auto-close scheduling model of a low-power DDR SDRAM: per-bank tracking
  and command-spacing checks on the link clock, status crossed to mclk.
  Assumes the controller's command clock runs freely while rst is low and
  that commands arrive already sampled on that clock.
*/
// Notes on behaviour
// - Flag low: burst, bank stays open
// - Flag high: auto-close engaged
// - Read close at max of two points
// - Write close after recovery time
// - Reads to other banks seamless
// - Writes to other banks seamless
// - Close period from latest close
`timescale 1ns/1ps
module lpac_top (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic                              link_ck,
  input  wire lpac_pkg::lpac_cmd_s               cmd,
  output logic [lpac_pkg::NUM_BANKS-1:0]         bank_open,
  output logic [lpac_pkg::NUM_BANKS-1:0]         bank_busy,
  output lpac_pkg::lpac_err_s                    cmd_err
);

  localparam int STAT_W = 2 * lpac_pkg::NUM_BANKS + lpac_pkg::ERR_W;

  // Reset reaches the link domain through its own synchroniser
  logic [lpac_pkg::SYNC_STAGES-1:0] lrst_q;
  wire                              link_rst = lrst_q[lpac_pkg::SYNC_STAGES-1];

  always_ff @(posedge link_ck)
  begin
    lrst_q <= {lrst_q[lpac_pkg::SYNC_STAGES-2:0], rst};
  end

  // Per-bank trackers
  lpac_pkg::lpac_bank_e         bstate [lpac_pkg::NUM_BANKS];
  lpac_pkg::lpac_err_s          berr   [lpac_pkg::NUM_BANKS];
  logic [lpac_pkg::NUM_BANKS-1:0] open_l;
  logic [lpac_pkg::NUM_BANKS-1:0] busy_l;
  logic [lpac_pkg::NUM_BANKS-1:0] act_e;
  logic [lpac_pkg::NUM_BANKS-1:0] acc_e;
  logic [lpac_pkg::NUM_BANKS-1:0] cls_e;

  function automatic logic bank_hit(input lpac_pkg::lpac_cmd_s c, input int idx);
    return c.op == lpac_pkg::CMD_CLOSE_ALL || c.bank == lpac_pkg::BANK_W'(idx);
  endfunction

  for (genvar b = 0; b < lpac_pkg::NUM_BANKS; b++)
  begin : g_bank
    lpac_bank u_bank (
      .ck       (link_ck),
      .link_rst (link_rst),
      .cmd      (cmd),
      .hit      (bank_hit(cmd, b)),
      .state_q  (bstate[b]),
      .err      (berr[b])
    );
    assign open_l[b] = bstate[b] == lpac_pkg::B_OPEN;
    assign busy_l[b] = bstate[b] == lpac_pkg::B_AP_PEND || bstate[b] == lpac_pkg::B_CLOSING;
    assign act_e[b]  = berr[b].act;
    assign acc_e[b]  = berr[b].access;
    assign cls_e[b]  = berr[b].close;
  end

  // Most recent read or write, for burst stop and turnaround checks
  logic [lpac_pkg::CNT_W-1:0]  age_q;
  logic                        seen_q;
  logic                        last_wr_q;
  logic                        last_ap_q;
  logic                        bst_used_q;
  logic [lpac_pkg::BANK_W-1:0] last_bank_q;

  wire is_rd  = cmd.valid && cmd.op == lpac_pkg::CMD_RD;
  wire is_wr  = cmd.valid && cmd.op == lpac_pkg::CMD_WR;
  wire is_bst = cmd.valid && cmd.op == lpac_pkg::CMD_BST;
  wire is_acc = is_rd || is_wr;
  wire age_up = age_q != lpac_pkg::AGE_MAX;

  // Prefetch of four lets a stop land only an even cycle count after the access
  wire bst_in_win = seen_q && age_q != '0 && age_q <= lpac_pkg::BST_LAST && !age_q[0];
  wire bst_bad    = is_bst && (!bst_in_win || last_ap_q || bst_used_q);

  // Back-to-back accesses must keep the half-burst spacing
  wire gap_bad  = is_acc && seen_q && age_q < lpac_pkg::SEAMLESS_GAP;
  wire wtr_bad  = is_rd && seen_q && last_wr_q && last_ap_q && cmd.bank != last_bank_q
                  && age_q < lpac_pkg::WRAP_TO_RD;

  lpac_pkg::lpac_err_s err_now;
  lpac_pkg::lpac_err_s err_q;

  // Any command inside a required spacing is recorded as illegal
  assign err_now.act     = |act_e;
  assign err_now.access  = |acc_e;
  assign err_now.close   = |cls_e;
  assign err_now.burst_stop_cmd     = bst_bad;
  assign err_now.spacing = gap_bad || wtr_bad;

  always_ff @(posedge link_ck)
  begin
    if (link_rst)
    begin
      age_q       <= '0;
      seen_q      <= 1'b0;
      last_wr_q   <= 1'b0;
      last_ap_q   <= 1'b0;
      bst_used_q  <= 1'b0;
      last_bank_q <= '0;
      err_q       <= '0;
    end
    else
    begin
      err_q <= err_q | err_now;
      if (is_acc)
      begin
        age_q       <= lpac_pkg::CNT_W'(1);
        seen_q      <= 1'b1;
        last_wr_q   <= is_wr;
        last_ap_q   <= cmd.auto_close_flag;
        bst_used_q  <= 1'b0;
        last_bank_q <= cmd.bank;
      end
      else
      begin
        age_q      <= age_up ? age_q + lpac_pkg::CNT_W'(1) : age_q;
        bst_used_q <= bst_used_q || is_bst;
      end
    end
  end

  // Status crosses as independent levels; each bit is meaningful alone,
  // so no word-coherent handshake is needed
  logic [STAT_W-1:0] stat_l;
  logic [STAT_W-1:0] stat_meta_q;
  logic [STAT_W-1:0] stat_q;

  always_ff @(posedge link_ck)
  begin
    if (link_rst)
      stat_l <= '0;
    else
      stat_l <= {open_l, busy_l, err_q};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stat_meta_q <= '0;
      stat_q      <= '0;
    end
    else
    begin
      stat_meta_q <= stat_l;
      stat_q      <= stat_meta_q;
    end
  end

  assign bank_open = stat_q[STAT_W-1 -: lpac_pkg::NUM_BANKS];
  assign bank_busy = stat_q[lpac_pkg::ERR_W +: lpac_pkg::NUM_BANKS];
  assign cmd_err   = stat_q[lpac_pkg::ERR_W-1:0];

endmodule

// [test/lpac_ctl_model.sv]
/* Controller model driving the link command port.
   Assumes link_ck runs freely and the bench calls its tasks. */
`timescale 1ns/1ps
module lpac_ctl_model (
  input  logic                link_ck,
  output lpac_pkg::lpac_cmd_s cmd
);
  initial cmd = '0;
  task automatic issue(input lpac_pkg::lpac_op_e op, input int b, input bit ap);
    @(posedge link_ck);
    #1 cmd = '{1'b1, op, 3'(b), ap};
  endtask
  // Idle cycles carry changing junk so a stale command cannot pass unnoticed
  task automatic gap(input int n);
    repeat (n)
    begin
      @(posedge link_ck);
      #1 cmd = '{1'b0, lpac_pkg::lpac_op_e'($urandom_range(6)), 3'($urandom), 1'($urandom)};
    end
  endtask
endmodule

// [test/lpac_top_asserts.sv]
/* Port checks for lpac_top.
   Assumes it is bound into lpac_top and sees only its ports. */
`timescale 1ns/1ps
module lpac_top_asserts (
  input logic                           mclk,
  input logic                           rst,
  input logic                           link_ck,
  input lpac_pkg::lpac_cmd_s            cmd,
  input logic [lpac_pkg::NUM_BANKS-1:0] bank_open,
  input logic [lpac_pkg::NUM_BANKS-1:0] bank_busy,
  input lpac_pkg::lpac_err_s            cmd_err
);
  localparam int RDI = lpac_pkg::RD_AP_START + lpac_pkg::CLOSE_CYC;
  localparam int WRI = lpac_pkg::WR_AP_START + lpac_pkg::CLOSE_CYC;
  logic [7:0] age_q;
  logic       rd_q;
  wire        acc = cmd.valid && (cmd.op == lpac_pkg::CMD_RD || cmd.op == lpac_pkg::CMD_WR);
  // Link cycles since the last access; saturates so old history never wraps back
  always_ff @(posedge link_ck)
  begin
    if (rst)
      age_q <= 8'hFF;
    else if (acc)
      age_q <= 8'h01;
    else if (age_q != 8'hFF)
      age_q <= age_q + 8'h01;
    if (acc)
      rd_q <= cmd.op == lpac_pkg::CMD_RD;
  end
  rst_clear_a: assert property (@(posedge mclk)
    rst |=> bank_open == 8'h00 && bank_busy == 8'h00 && cmd_err == 5'h00)
    else $error("outputs not clear after reset");
  err_sticky_a: assert property (@(posedge mclk) disable iff (rst)
    (cmd_err & $past(cmd_err)) == $past(cmd_err))
    else $error("error bit dropped");
  busy_bound_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(bank_busy[1]) |-> ##[1:80] !bank_busy[1])
    else $error("bank stuck closing");
  act_open_a: assert property (@(posedge link_ck) disable iff (rst)
    cmd.valid && cmd.op == lpac_pkg::CMD_ACT && cmd.bank == 3'h1
    |-> ##[1:3] (bank_open[1] || cmd_err.act))
    else $error("activate had no effect");
  rd_ap_a: assert property (@(posedge link_ck) disable iff (rst)
    cmd.valid && cmd.op == lpac_pkg::CMD_RD && cmd.auto_close_flag && cmd.bank == 3'h1
    && bank_open[1] |-> ##RDI bank_busy[1] ##[1:3] !bank_busy[1])
    else $error("read auto-close timing wrong");
  wr_ap_a: assert property (@(posedge link_ck) disable iff (rst)
    cmd.valid && cmd.op == lpac_pkg::CMD_WR && cmd.auto_close_flag && cmd.bank == 3'h1
    && bank_open[1] |-> ##WRI bank_busy[1] ##[1:3] !bank_busy[1])
    else $error("write auto-close timing wrong");
  access_spacing_a: assert property (@(posedge link_ck) disable iff (rst)
    acc && age_q < lpac_pkg::HALF_BL |-> ##[1:3] cmd_err.spacing)
    else $error("close access spacing not flagged");
  close_early_a: assert property (@(posedge link_ck) disable iff (rst)
    cmd.valid && cmd.op == lpac_pkg::CMD_CLOSE_ALL && rd_q && age_q < lpac_pkg::RD_CLOSE_DLY
    |-> ##[1:3] cmd_err.close)
    else $error("early close not flagged");
endmodule
bind lpac_top lpac_top_asserts chk_u (.mclk(mclk), .rst(rst), .link_ck(link_ck), .cmd(cmd),
  .bank_open(bank_open), .bank_busy(bank_busy), .cmd_err(cmd_err));

// [test/sdram_auto_close_scheduling_tb_top.sv]
/* Self-checking bench for lpac_top with a bank-state reference model.
   Assumes lpac_ctl_model drives the link port and the checker is bound. */
`timescale 1ns/1ps
module sdram_auto_close_scheduling_tb_top;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                link_ck = 1'b0;
  lpac_pkg::lpac_cmd_s cmd;
  logic [7:0]          bank_open;
  logic [7:0]          bank_busy;
  lpac_pkg::lpac_err_s cmd_err;
  lpac_pkg::lpac_err_s e_err = '0;
  int                  error_cnt = 0, n_checks = 0, cyc = 0, last_acc = -99, last_bank, age;
  bit                  last_rd, last_ap, bst_done;
  int                  st[8];
  always #5 mclk = ~mclk;
  always #32 link_ck = ~link_ck;
  lpac_top dut_u (.mclk(mclk), .rst(rst), .link_ck(link_ck), .cmd(cmd),
    .bank_open(bank_open), .bank_busy(bank_busy), .cmd_err(cmd_err));
  lpac_ctl_model ctl_u (.link_ck(link_ck), .cmd(cmd));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    cyc += n;
    ctl_u.gap(n);
  endtask
  // Reference model: updates expected state, then hands the command over
  task automatic send(input lpac_pkg::lpac_op_e op, input int b, input bit ap);
    age = cyc - last_acc;
    case (op)
      lpac_pkg::CMD_ACT:
      begin
        if (st[b] != 0) e_err.act = 1'b1;
        st[b] = 1;
      end
      lpac_pkg::CMD_RD, lpac_pkg::CMD_WR:
      begin
        if (st[b] != 1) e_err.access = 1'b1;
        if (age < lpac_pkg::HALF_BL) e_err.spacing = 1'b1;
        if (op == lpac_pkg::CMD_RD && !last_rd && last_ap && b != last_bank &&
            age < lpac_pkg::WRAP_TO_RD)
          e_err.spacing = 1'b1;
        if (ap) st[b] = 0;
        last_acc = cyc;
        last_bank = b;
        last_rd = op == lpac_pkg::CMD_RD;
        last_ap = ap;
        bst_done = 0;
      end
      lpac_pkg::CMD_BST:
      begin
        if (age == 0 || age[0] || age > lpac_pkg::BST_LAST || last_ap || bst_done)
          e_err.burst_stop_cmd = 1'b1;
        bst_done = 1;
      end
      default:
      begin
        if ((op == lpac_pkg::CMD_CLOSE_ALL || b == last_bank) &&
            age < (last_rd ? lpac_pkg::RD_CLOSE_DLY : lpac_pkg::WR_CLOSE_DLY))
          e_err.close = 1'b1;
        for (int i = 0; i < 8; i++)
          if (op == lpac_pkg::CMD_CLOSE_ALL || i == b) st[i] = 0;
      end
    endcase
    cyc++;
    ctl_u.issue(op, b, ap);
  endtask
  task automatic settle(input string nm);
    logic [7:0] exp_open;
    idle(14);
    repeat (4) @(posedge mclk);
    #1;
    for (int i = 0; i < 8; i++) exp_open[i] = st[i] == 1;
    check({nm, " open"}, bank_open, exp_open);
    check({nm, " busy"}, bank_busy, 8'h00);
    check({nm, " err"}, 8'(cmd_err), 8'(e_err));
    $display("test %s done", nm);
  endtask
  initial
  begin
    st = '{default: 0};
    void'($urandom(42));
    repeat (4) @(posedge link_ck);
    check("reset err", 8'(cmd_err), 8'h00);
    @(posedge mclk);
    #1 rst = 1'b0;
    idle(3);
    for (int i = 0; i < 8; i++) send(lpac_pkg::CMD_ACT, i, 1'b0);
    settle("act all");
    repeat (4)
    begin
      send(lpac_pkg::CMD_RD, $urandom_range(7), 1'b0);
      idle(lpac_pkg::HALF_BL - 1);
    end
    settle("rd plain");
    send(lpac_pkg::CMD_RD, 1, 1'b1);
    idle(lpac_pkg::HALF_BL - 1);
    send(lpac_pkg::CMD_RD, 2, 1'b0);
    idle(lpac_pkg::RD_AP_START + lpac_pkg::CLOSE_CYC - lpac_pkg::HALF_BL - 1);
    send(lpac_pkg::CMD_ACT, 1, 1'b0);
    settle("rd ap");
    send(lpac_pkg::CMD_WR, 1, 1'b1);
    idle(lpac_pkg::HALF_BL - 1);
    send(lpac_pkg::CMD_WR, 4, 1'b0);
    idle(lpac_pkg::WR_AP_START + lpac_pkg::CLOSE_CYC - lpac_pkg::HALF_BL - 1);
    send(lpac_pkg::CMD_ACT, 1, 1'b0);
    settle("wr ap");
    send(lpac_pkg::CMD_RD, 2, 1'b0);
    idle(1);
    send(lpac_pkg::CMD_BST, 0, 1'b0);
    idle(lpac_pkg::RD_CLOSE_DLY - 3);
    send(lpac_pkg::CMD_CLOSE, 2, 1'b0);
    send(lpac_pkg::CMD_CLOSE, 6, 1'b0);
    send(lpac_pkg::CMD_CLOSE_ALL, 0, 1'b0);
    idle(lpac_pkg::CLOSE_CYC - 1);
    for (int i = 0; i < 8; i++) send(lpac_pkg::CMD_ACT, i, 1'b0);
    send(lpac_pkg::CMD_WR, 0, 1'b0);
    idle(lpac_pkg::WR_CLOSE_DLY - 1);
    send(lpac_pkg::CMD_CLOSE, 0, 1'b0);
    settle("close spacing");
    send(lpac_pkg::CMD_WR, 5, 1'b1);
    idle(1);
    send(lpac_pkg::CMD_BST, 0, 1'b0);
    idle(2);
    send(lpac_pkg::CMD_RD, 3, 1'b0);
    idle(3);
    // Bank 5 has already auto-closed back to idle, so a second write there must be flagged
    send(lpac_pkg::CMD_WR, 5, 1'b0);
    settle("wr ap faults");
    send(lpac_pkg::CMD_RD, 4, 1'b0);
    idle(lpac_pkg::RD_CLOSE_DLY - 2);
    send(lpac_pkg::CMD_CLOSE_ALL, 0, 1'b0);
    settle("early close");
    send(lpac_pkg::CMD_ACT, 2, 1'b0);
    send(lpac_pkg::CMD_ACT, 2, 1'b0);
    send(lpac_pkg::CMD_RD, 3, 1'b0);
    send(lpac_pkg::CMD_RD, 6, 1'b0);
    settle("illegal");
    finish_test();
  end
  initial
  begin
    #100000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end
endmodule
